// File: lpbias_pkg.sv
package lpbias_pkg;
    // ========================================
    // Register map
    localparam logic [15:0] LPBIAS_REF_CTRL_OFS = 16'h2050;
    localparam logic [15:0] LPBIAS_DAC_DATA_OFS = 16'h2120;
    localparam logic [15:0] LPBIAS_DAC_CTRL_OFS = 16'h2128;
    localparam logic [15:0] LPBIAS_AMP_CTRL_OFS = 16'h20ec;
    localparam logic [15:0] LPBIAS_AMP_SW_OFS = 16'h20e4;
    localparam logic [15:0] LPBIAS_CM_SW_OFS = 16'h235c;
    // ========================================
    // Field positions and widths
    localparam int LPBIAS_FINE_LSB = 0;
    localparam int LPBIAS_FINE_W = 12;
    localparam int LPBIAS_COARSE_LSB = 12;
    localparam int LPBIAS_COARSE_W = 6;
    localparam int LPBIAS_BUF_PD_BIT = 1;
    localparam int LPBIAS_BG_PD_BIT = 0;
    localparam int LPBIAS_CM_SW_BIT = 3;
    localparam int LPBIAS_WREN_BIT = 0;
    localparam int LPBIAS_GAIN_LSB = 5;
    localparam int LPBIAS_GAIN_W = 5;
    localparam int LPBIAS_AMP_SW_W = 14;
    localparam int LPBIAS_DIODE_SW = 0;
    localparam int LPBIAS_BUFMODE_SW = 10;
    // Force/sense switches closed by a gain write
    localparam logic [13:0] LPBIAS_FS_SW_MASK = 14'h3000;
    // ========================================
    // Reset values
    localparam logic [31:0] LPBIAS_RESET_VAL = 32'h0000_0000;
    localparam logic [31:0] LPBIAS_UNMAPPED_VAL = 32'h0000_0000;

    typedef struct packed {
        logic buffer_powerdown;
        logic bandgap_powerdown;
        logic common_mode_switch_on;
        logic [13:0] amp_switches;
        logic potentiostat_unity_buffer;
        logic [4:0] amp_gain_select;
        logic [5:0] coarse_bias_code;
        logic [11:0] fine_bias_code;
    } lpbias_ctrl_t;
endpackage : lpbias_pkg

// File: lpbias_regs.sv
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module lpbias_regs (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [15:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output lpbias_pkg::lpbias_ctrl_t ctrl_o
);
    // All checks run on the one clock and sleep during reset
    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // ========================================
    // Bus handshake: one wait cycle, answer on the second edge
    logic ack_reg;
    logic [31:0] wdata;
    logic wr_go;
    logic rd_go;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wdata[i*8 +: 8] = avs_byteenable_i[i] ?
                avs_writedata_i[i*8 +: 8] : 8'h00;
        end
    end
    assign wr_go = avs_write_i && !ack_reg;
    assign rd_go = avs_read_i && !ack_reg;
    // Byte lane merge keeps the unselected bytes
    function automatic logic [31:0] merge(input logic [31:0] old_v);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = avs_byteenable_i[i] ? 8'hff : 8'h00;
        end
        return (old_v & ~m) | (wdata & m);
    endfunction

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
        end
    end
    // Registered so the pin comes straight from a flop
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_reg);
        end
    end

    // ========================================
    // Registers
    logic [31:0] ref_reg;
    logic [31:0] dac_reg;
    logic [31:0] dacctl_reg;
    logic [31:0] ampctl_reg;
    logic [31:0] ampsw_reg;
    logic [31:0] cm_reg;
    logic [31:0] ampsw_next;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ref_reg <= lpbias_pkg::LPBIAS_RESET_VAL;
            cm_reg <= lpbias_pkg::LPBIAS_RESET_VAL;
            dacctl_reg <= lpbias_pkg::LPBIAS_RESET_VAL;
            ampctl_reg <= lpbias_pkg::LPBIAS_RESET_VAL;
        end else if (wr_go) begin
            if (avs_address_i == lpbias_pkg::LPBIAS_REF_CTRL_OFS) begin
                ref_reg <= merge(ref_reg) & 32'h0000_0003;
            end else if (avs_address_i == lpbias_pkg::LPBIAS_CM_SW_OFS) begin
                cm_reg <= merge(cm_reg) & 32'h0000_0008;
            end else if (avs_address_i ==
                    lpbias_pkg::LPBIAS_DAC_CTRL_OFS) begin
                dacctl_reg <= merge(dacctl_reg) & 32'h0000_0001;
            end else if (avs_address_i ==
                    lpbias_pkg::LPBIAS_AMP_CTRL_OFS) begin
                ampctl_reg <= merge(ampctl_reg) & 32'h0000_03e0;
            end
        end
    end

    // Gain write forces the force/sense pair closed
    always_comb begin
        ampsw_next = merge(ampsw_reg) & 32'h0000_3fff;
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ampsw_reg <= lpbias_pkg::LPBIAS_RESET_VAL;
        end else if (wr_go &&
                avs_address_i == lpbias_pkg::LPBIAS_AMP_SW_OFS) begin
            ampsw_reg <= ampsw_next;
        end else if (wr_go &&
                avs_address_i == lpbias_pkg::LPBIAS_AMP_CTRL_OFS &&
                (avs_byteenable_i[0] || avs_byteenable_i[1])) begin
            ampsw_reg <= ampsw_reg |
                {18'h00000, lpbias_pkg::LPBIAS_FS_SW_MASK};
        end
    end

    // Data register is held clear while writes are disabled
    always_ff @(posedge clk_i) begin
        if (reset_i || !dacctl_reg[lpbias_pkg::LPBIAS_WREN_BIT]) begin
            dac_reg <= lpbias_pkg::LPBIAS_RESET_VAL;
        end else if (wr_go &&
                avs_address_i == lpbias_pkg::LPBIAS_DAC_DATA_OFS) begin
            dac_reg <= merge(dac_reg) & 32'h0003_ffff;
        end
    end

    // ========================================
    // Read path
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            avs_readdata_o <= lpbias_pkg::LPBIAS_UNMAPPED_VAL;
        end else if (rd_go) begin
            if (avs_address_i == lpbias_pkg::LPBIAS_REF_CTRL_OFS) begin
                avs_readdata_o <= ref_reg;
            end else if (avs_address_i ==
                    lpbias_pkg::LPBIAS_DAC_DATA_OFS) begin
                avs_readdata_o <= dac_reg;
            end else if (avs_address_i ==
                    lpbias_pkg::LPBIAS_DAC_CTRL_OFS) begin
                avs_readdata_o <= dacctl_reg;
            end else if (avs_address_i ==
                    lpbias_pkg::LPBIAS_AMP_CTRL_OFS) begin
                avs_readdata_o <= ampctl_reg;
            end else if (avs_address_i == lpbias_pkg::LPBIAS_AMP_SW_OFS) begin
                avs_readdata_o <= ampsw_reg;
            end else if (avs_address_i == lpbias_pkg::LPBIAS_CM_SW_OFS) begin
                avs_readdata_o <= cm_reg;
            end else begin
                avs_readdata_o <= lpbias_pkg::LPBIAS_UNMAPPED_VAL;
            end
        end
    end

    // ========================================
    // Analog control outputs, registered
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_o <= '0;
        end else begin
            ctrl_o.buffer_powerdown <=
                ref_reg[lpbias_pkg::LPBIAS_BUF_PD_BIT];
            ctrl_o.bandgap_powerdown <=
                ref_reg[lpbias_pkg::LPBIAS_BG_PD_BIT];
            ctrl_o.common_mode_switch_on <=
                cm_reg[lpbias_pkg::LPBIAS_CM_SW_BIT];
            ctrl_o.amp_switches <= ampsw_reg[13:0];
            ctrl_o.potentiostat_unity_buffer <=
                ampsw_reg[lpbias_pkg::LPBIAS_BUFMODE_SW];
            ctrl_o.amp_gain_select <= ampctl_reg[9:5];
            ctrl_o.coarse_bias_code <= dac_reg[17:12];
            ctrl_o.fine_bias_code <= dac_reg[11:0];
        end
    end

    // ========================================
    // Check helpers
    // Decoder kept apart from the read mux so a broken mux still trips
    logic addr_mapped;
    always_comb begin
        if (avs_address_i == lpbias_pkg::LPBIAS_REF_CTRL_OFS) begin
            addr_mapped = 1'b1;
        end else if (avs_address_i == lpbias_pkg::LPBIAS_DAC_DATA_OFS) begin
            addr_mapped = 1'b1;
        end else if (avs_address_i == lpbias_pkg::LPBIAS_DAC_CTRL_OFS) begin
            addr_mapped = 1'b1;
        end else if (avs_address_i == lpbias_pkg::LPBIAS_AMP_CTRL_OFS) begin
            addr_mapped = 1'b1;
        end else if (avs_address_i == lpbias_pkg::LPBIAS_AMP_SW_OFS) begin
            addr_mapped = 1'b1;
        end else if (avs_address_i == lpbias_pkg::LPBIAS_CM_SW_OFS) begin
            addr_mapped = 1'b1;
        end else begin
            addr_mapped = 1'b0;
        end
    end

    // ========================================
    // Check sequences
    sequence req_taken_s;
        (avs_read_i || avs_write_i) && !ack_reg;
    endsequence
    sequence gain_write_s;
        wr_go && avs_address_i == lpbias_pkg::LPBIAS_AMP_CTRL_OFS &&
            (avs_byteenable_i[0] || avs_byteenable_i[1]);
    endsequence
    sequence ref_write_s;
        wr_go && avs_address_i == lpbias_pkg::LPBIAS_REF_CTRL_OFS &&
            avs_byteenable_i[0];
    endsequence
    sequence cm_write_s;
        wr_go && avs_address_i == lpbias_pkg::LPBIAS_CM_SW_OFS &&
            avs_byteenable_i[0];
    endsequence
    sequence dac_write_s;
        wr_go && avs_address_i == lpbias_pkg::LPBIAS_DAC_DATA_OFS &&
            dacctl_reg[0] && avs_byteenable_i == 4'hf;
    endsequence
    sequence dac_refused_s;
        wr_go && avs_address_i == lpbias_pkg::LPBIAS_DAC_DATA_OFS &&
            !dacctl_reg[0];
    endsequence
    sequence sw_write_s;
        wr_go && avs_address_i == lpbias_pkg::LPBIAS_AMP_SW_OFS &&
            avs_byteenable_i[1:0] == 2'b11;
    endsequence
    sequence unmapped_read_s;
        rd_go && !addr_mapped;
    endsequence

    // ========================================
    // Checks: bus handshake
    answer_next_a: assert property (
        req_taken_s |=> !avs_waitrequest_o)
        else $error("waitrequest not low after a taken request");
    wait_one_a: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    rdata_hold_a: assert property (
        !rd_go |=> $stable(avs_readdata_o))
        else $error("read data changed without a read");
    unmapped_read_a: assert property (
        unmapped_read_s |=> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");

    // ========================================
    // Checks: register writes
    ref_write_a: assert property (
        ref_write_s |=> ref_reg[1:0] == $past(avs_writedata_i[1:0]))
        else $error("reference control write not taken");
    ref_hold_a: assert property (
        !(wr_go && avs_address_i == lpbias_pkg::LPBIAS_REF_CTRL_OFS)
        |=> $stable(ref_reg))
        else $error("reference control changed without a write");
    cm_write_a: assert property (
        cm_write_s |=> cm_reg[3] == $past(avs_writedata_i[3]))
        else $error("common mode switch write not taken");
    dac_write_a: assert property (
        dac_write_s |=> dac_reg[17:0] == $past(avs_writedata_i[17:0]))
        else $error("dac data write not taken");
    dac_refused_a: assert property (
        dac_refused_s |=> dac_reg == 32'h0)
        else $error("dac data write taken while disabled");
    dac_held_zero_a: assert property (
        !dacctl_reg[0] |=> dac_reg == 32'h0)
        else $error("dac data not zero while writes disabled");
    ampsw_write_a: assert property (
        sw_write_s |=> ampsw_reg[13:0] == $past(avs_writedata_i[13:0]))
        else $error("amplifier switch write not taken");
    gain_closes_fs_a: assert property (
        gain_write_s |=> ampsw_reg[13:12] == 2'b11)
        else $error("force/sense switches not closed by gain write");
    gain_keeps_sw_a: assert property (
        gain_write_s |=> ampsw_reg[11:0] == $past(ampsw_reg[11:0]))
        else $error("gain write disturbed other switches");
    reserved_zero_a: assert property (
        ref_reg[31:2] == '0 && cm_reg[2:0] == '0 && cm_reg[31:4] == '0 &&
        ampsw_reg[31:14] == '0 && dac_reg[31:18] == '0 &&
        dacctl_reg[31:1] == '0 && ampctl_reg[4:0] == '0 &&
        ampctl_reg[31:10] == '0)
        else $error("reserved bits not zero");

    // ========================================
    // Checks: analog control outputs, one clock behind the registers
    fine_out_a: assert property (
        ##1 ctrl_o.fine_bias_code == $past(dac_reg[11:0]))
        else $error("fine code output mismatch");
    coarse_out_a: assert property (
        ##1 ctrl_o.coarse_bias_code == $past(dac_reg[17:12]))
        else $error("coarse code output mismatch");
    buf_pd_out_a: assert property (
        ##1 ctrl_o.buffer_powerdown == $past(ref_reg[1]))
        else $error("buffer powerdown mismatch");
    bg_pd_out_a: assert property (
        ##1 ctrl_o.bandgap_powerdown == $past(ref_reg[0]))
        else $error("bandgap powerdown mismatch");
    cm_out_a: assert property (
        ##1 ctrl_o.common_mode_switch_on == $past(cm_reg[3]))
        else $error("common mode switch mismatch");
    diode_sw_a: assert property (
        ##1 ctrl_o.amp_switches[0] == $past(ampsw_reg[0]))
        else $error("diode switch mismatch");
    amp_sw_out_a: assert property (
        ##1 ctrl_o.amp_switches == $past(ampsw_reg[13:0]))
        else $error("amplifier switch output mismatch");
    unity_buf_a: assert property (
        ##1 ctrl_o.potentiostat_unity_buffer == $past(ampsw_reg[10]))
        else $error("unity buffer mode mismatch");
    gain_out_a: assert property (
        ##1 ctrl_o.amp_gain_select == $past(ampctl_reg[9:5]))
        else $error("gain select output mismatch");
endmodule // lpbias_regs
`default_nettype wire

// File: lpbias_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lpbias_regs_tb;
    // ========================================
    // Stimulus and observed signals
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [15:0] adr = 16'h0000;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] be = 4'hf;
    logic [31:0] rdat;
    logic wait_req;
    lpbias_pkg::lpbias_ctrl_t ctrl;
    int fail_count = 0;
    int comparisons = 0;
    localparam logic [15:0] REF = lpbias_pkg::LPBIAS_REF_CTRL_OFS;
    localparam logic [15:0] DAT = lpbias_pkg::LPBIAS_DAC_DATA_OFS;
    localparam logic [15:0] DCT = lpbias_pkg::LPBIAS_DAC_CTRL_OFS;
    localparam logic [15:0] AMP = lpbias_pkg::LPBIAS_AMP_CTRL_OFS;
    localparam logic [15:0] SWR = lpbias_pkg::LPBIAS_AMP_SW_OFS;
    localparam logic [15:0] CMS = lpbias_pkg::LPBIAS_CM_SW_OFS;

    always #2.5 clk_i = ~clk_i;

    lpbias_regs uut (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .avs_address_i(adr),
        .avs_read_i(rd_en),
        .avs_write_i(wr_en),
        .avs_writedata_i(wdat),
        .avs_byteenable_i(be),
        .avs_readdata_o(rdat),
        .avs_waitrequest_o(wait_req),
        .ctrl_o(ctrl)
    );

    // ========================================
    // Bus access and comparison tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Entered just after a rising edge; the extra edge at the end keeps
    // release and the next request out of the same time step
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [31:0] d, input logic [3:0] m,
                       output logic [31:0] q);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        be <= m;
        wr_en <= w;
        rd_en <= ~w;
        do begin
            @(posedge clk_i);
            n++;
        end while (wait_req !== 1'b0 && n < 20);
        if (n >= 20) chk(32'(wait_req), 32'h0);
        q = rdat;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] m = 4'hf);
        logic [31:0] q;
        acc(1'b1, a, d, m, q);
    endtask

    task automatic rc(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, 4'hf, q);
        chk(q, e);
    endtask

    task automatic end_sim;
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ========================================
    // Test sequence
    initial begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rc(REF, 32'h0);
        rc(DAT, 32'h0);
        rc(CMS, 32'h0);
        rc(SWR, 32'h0);
        rc(DCT, 32'h0);
        wr(DAT, 32'h0003_f123);
        rc(DAT, 32'h0);
        wr(DCT, 32'hffff_ffff);
        rc(DCT, 32'h1);
        wr(DAT, 32'hffff_ffff);
        rc(DAT, 32'h0003_ffff);
        chk(32'(ctrl.fine_bias_code), 32'hfff);
        chk(32'(ctrl.coarse_bias_code), 32'h3f);
        // Lane 2 alone: only bits 17:16 of the coarse code change
        wr(DAT, 32'h0002_5000, 4'b0100);
        rc(DAT, 32'h0002_ffff);
        wr(DAT, 32'h0001_5a5a);
        chk(32'(ctrl.fine_bias_code), 32'ha5a);
        chk(32'(ctrl.coarse_bias_code), 32'h15);
        wr(DCT, 32'h0);
        rc(DAT, 32'h0);
        chk(32'(ctrl.fine_bias_code), 32'h0);
        chk(32'(ctrl.coarse_bias_code), 32'h0);
        wr(REF, 32'hffff_ffff);
        rc(REF, 32'h3);
        chk(32'(ctrl.buffer_powerdown), 32'h1);
        chk(32'(ctrl.bandgap_powerdown), 32'h1);
        wr(REF, 32'h2);
        chk(32'(ctrl.buffer_powerdown), 32'h1);
        chk(32'(ctrl.bandgap_powerdown), 32'h0);
        wr(REF, 32'h1);
        chk(32'(ctrl.buffer_powerdown), 32'h0);
        chk(32'(ctrl.bandgap_powerdown), 32'h1);
        wr(CMS, 32'hffff_ffff);
        rc(CMS, 32'h8);
        chk(32'(ctrl.common_mode_switch_on), 32'h1);
        wr(CMS, 32'h7);
        rc(CMS, 32'h0);
        chk(32'(ctrl.common_mode_switch_on), 32'h0);
        wr(SWR, 32'h0401);
        rc(SWR, 32'h0401);
        chk(32'(ctrl.amp_switches), 32'h0401);
        chk(32'(ctrl.potentiostat_unity_buffer), 32'h1);
        wr(SWR, 32'hffff_ffff);
        rc(SWR, 32'h3fff);
        wr(SWR, 32'h0);
        chk(32'(ctrl.potentiostat_unity_buffer), 32'h0);
        chk(32'(ctrl.amp_switches), 32'h0);
        wr(SWR, 32'h0001);
        chk(32'(ctrl.amp_switches), 32'h0001);
        wr(SWR, 32'h0);
        wr(AMP, 32'hffff_ffff);
        rc(AMP, 32'h0000_03e0);
        rc(SWR, 32'h0000_3000);
        chk(32'(ctrl.amp_gain_select), 32'h1f);
        chk(32'(ctrl.amp_switches), 32'h3000);
        wr(SWR, 32'h0);
        wr(AMP, 32'h0000_0020);
        rc(SWR, 32'h0000_3000);
        chk(32'(ctrl.amp_gain_select), 32'h1);
        // A lane above the gain field leaves the switches alone
        wr(SWR, 32'h0);
        wr(AMP, 32'h0001_0000, 4'b0100);
        rc(SWR, 32'h0);
        rc(16'h2000, 32'h0);
        end_sim();
    end

    // Sequence needs under 2 us; the margin covers a stuck handshake
    initial begin
        #20000;
        fail_count++;
        end_sim();
    end
endmodule // lpbias_regs_tb
`default_nettype wire
